// ===== hw/hv_meas_pkg.sv
// Purpose: Constants for the high-voltage measurement path control
// Assumes: Mode codes come from the chip mode controller
// Notes: Mode and pin config codes are local choices
// Function
// RULE1 - After reset measurement is off, the path switch is open and both pins work normally.
// RULE2 - A set enable closes the path switch only in Normal mode and keeps it open elsewhere.
// RULE3 - Leaving Normal mode opens the switch but keeps the enable, so returning recloses it.
// RULE4 - While enabled, pulls on both pins are off and their inputs are cut from wake and level logic.
// RULE5 - While enabled, pull, wake source and general pin settings are stored but not applied.
// RULE6 - While enabled, wake event and wake level flags are not updated from the two pins.
// RULE7 - While enabled, a Sleep command with only the two pins as wake sources sets the fault flag and goes to Restart.
// RULE8 - While enabled, fail output driving, its test command and all pin general and wake functions are off.
// RULE9 - While enabled, any attempt to change the general pin setting sets the fault flag.
// RULE10 - Setting the enable is refused with a fault flag unless the general pin is configured off.
// RULE11 - While enabled, wake enable bits for the pins are stored but not acted on.
// RULE12 - Entering Fail-Safe with measurement on keeps the setting and holds the switch open.
// RULE13 - Entering Fail-Safe with measurement off enables the sense pin as a wake source.
// RULE14 - The fault flag stays set until software clears it, and a refused write keeps the old enable.
package hv_meas_pkg;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_STOP = 3'h1;
    localparam logic [2:0] MODE_SLEEP = 3'h2;
    localparam logic [2:0] MODE_RESTART = 3'h3;
    localparam logic [2:0] MODE_FAILSAFE = 3'h4;
    localparam logic [2:0] GPIO_CFG_OFF = 3'h0;
    localparam logic [2:0] GPIO_CFG_WAKE = 3'h1;
    localparam logic [1:0] PULL_WIDTH_CFG = 2'h2;
    localparam logic MEAS_RESET = 1'b0;
    localparam logic FAULT_RESET = 1'b0;
endpackage : hv_meas_pkg

// ===== hw/hv_pin_gate.sv
// Purpose: Gates pin settings and inputs while measurement is on
// Assumes: Inputs are already synchronised
// Notes: Purely combinational
`timescale 1ns/100ps
module hv_pin_gate (
    input wire logic i_meas,
    input wire logic [3:0] i_pull_cfg,
    input wire logic i_sense_in,
    input wire logic i_gpio_in,
    input wire logic i_sense_wake_en,
    input wire logic i_gpio_wake_en,
    input wire logic i_fail_drive,
    input wire logic i_gpio_drive,
    output logic [3:0] o_pull_cfg,
    output logic o_sense_in,
    output logic o_gpio_in,
    output logic o_sense_wake_en,
    output logic o_gpio_wake_en,
    output logic o_fail_drive,
    output logic o_gpio_drive
);
    always_comb begin
        o_pull_cfg = i_meas ? 4'h0 : i_pull_cfg; // [RULE4] [RULE5]
        o_sense_in = i_meas ? 1'b0 : i_sense_in; // [RULE4]
        o_gpio_in = i_meas ? 1'b0 : i_gpio_in; // [RULE4]
        o_sense_wake_en = i_meas ? 1'b0 : i_sense_wake_en; // [RULE11]
        o_gpio_wake_en = i_meas ? 1'b0 : i_gpio_wake_en; // [RULE11]
        o_fail_drive = i_meas ? 1'b0 : i_fail_drive; // [RULE8]
        o_gpio_drive = i_meas ? 1'b0 : i_gpio_drive; // [RULE8]
    end
endmodule : hv_pin_gate

// ===== hw/hv_measurement_path_control.sv
// Purpose: Measurement enable, path switch, pin gating and fault flag
// Assumes: Pin levels come from pads; control strobes come from the SPI logic on I_REF_CLK
// Notes: All outputs registered
`timescale 1ns/100ps
module hv_measurement_path_control (
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    input wire logic [2:0] I_MODE,
    input wire logic I_MEAS_WR,
    input wire logic I_MEAS_WDATA,
    input wire logic I_GPIO_CFG_WR,
    input wire logic [2:0] I_GPIO_CFG_WDATA,
    input wire logic I_FAULT_CLR,
    input wire logic I_SLEEP_CMD,
    input wire logic [3:0] I_PULL_CFG,
    input wire logic I_SENSE_WAKE_EN,
    input wire logic I_FAIL_OUTPUT_TEST,
    input wire logic I_FAIL_REQ,
    input wire logic I_GPIO_OUT,
    input wire logic I_SENSE_PIN,
    input wire logic I_GPIO_PIN,
    output logic O_MEAS_ENABLE,
    output logic O_PATH_SWITCH,
    output logic O_CMD_FAULT,
    output logic O_GOTO_RESTART,
    output logic O_GOTO_SLEEP,
    output logic [3:0] O_PULL_CFG,
    output logic O_SENSE_LEVEL,
    output logic O_GPIO_LEVEL,
    output logic O_STATUS_UPDATE_EN,
    output logic O_SENSE_WAKE_ACTIVE,
    output logic O_GPIO_WAKE_ACTIVE,
    output logic O_FAIL_DRIVE,
    output logic O_GPIO_DRIVE,
    output logic [2:0] O_GPIO_CFG
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] sense_sync;
    logic [1:0] gpio_sync;
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            sense_sync <= 2'h0;
            gpio_sync <= 2'h0;
        end else begin
            sense_sync <= {sense_sync[0], I_SENSE_PIN};
            gpio_sync <= {gpio_sync[0], I_GPIO_PIN};
        end
    end

    // ----------------------------------------
    // Enable and general pin configuration
    // ----------------------------------------
    logic meas;
    logic [2:0] gpio_cfg;
    logic set_refused;
    logic cfg_refused;
    logic sleep_refused;
    logic failsafe_q;
    logic fs_entry;
    logic fs_wake;
    assign set_refused = I_MEAS_WR && I_MEAS_WDATA && !meas && (gpio_cfg != hv_meas_pkg::GPIO_CFG_OFF);
    assign cfg_refused = I_GPIO_CFG_WR && meas;
    assign sleep_refused = I_SLEEP_CMD && meas;
    assign fs_entry = (I_MODE == hv_meas_pkg::MODE_FAILSAFE) && !failsafe_q;

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            meas <= hv_meas_pkg::MEAS_RESET; // [RULE1]
        end else if (I_MEAS_WR && !set_refused) begin
            meas <= I_MEAS_WDATA; // [RULE3] [RULE12] [RULE14]
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            gpio_cfg <= hv_meas_pkg::GPIO_CFG_OFF;
        end else if (I_GPIO_CFG_WR) begin
            gpio_cfg <= I_GPIO_CFG_WDATA; // [RULE5]
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            failsafe_q <= 1'b0;
            fs_wake <= 1'b0;
        end else begin
            failsafe_q <= (I_MODE == hv_meas_pkg::MODE_FAILSAFE);
            if (fs_entry && !meas) begin
                fs_wake <= 1'b1; // [RULE13]
            end else if (I_MODE == hv_meas_pkg::MODE_NORMAL) begin
                fs_wake <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Command fault flag
    // ----------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            O_CMD_FAULT <= hv_meas_pkg::FAULT_RESET;
        end else if (set_refused || cfg_refused || sleep_refused) begin
            O_CMD_FAULT <= 1'b1; // [RULE7] [RULE9] [RULE10] [RULE14]
        end else if (I_FAULT_CLR) begin
            O_CMD_FAULT <= 1'b0; // [RULE14]
        end
    end

    // ----------------------------------------
    // Sleep redirection
    // ----------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            O_GOTO_RESTART <= 1'b0;
            O_GOTO_SLEEP <= 1'b0;
        end else begin
            O_GOTO_RESTART <= sleep_refused; // [RULE7]
            O_GOTO_SLEEP <= I_SLEEP_CMD && !meas;
        end
    end

    // ----------------------------------------
    // Pin gating
    // ----------------------------------------
    logic [3:0] g_pull;
    logic g_sense;
    logic g_gpio;
    logic g_swake;
    logic g_gwake;
    logic g_fail;
    logic g_gdrv;
    hv_pin_gate u_gate (
        .i_meas(meas),
        .i_pull_cfg(I_PULL_CFG),
        .i_sense_in(sense_sync[1]),
        .i_gpio_in(gpio_sync[1]),
        .i_sense_wake_en(I_SENSE_WAKE_EN || fs_wake),
        .i_gpio_wake_en(gpio_cfg == hv_meas_pkg::GPIO_CFG_WAKE),
        .i_fail_drive(I_FAIL_REQ || I_FAIL_OUTPUT_TEST),
        .i_gpio_drive(I_GPIO_OUT),
        .o_pull_cfg(g_pull),
        .o_sense_in(g_sense),
        .o_gpio_in(g_gpio),
        .o_sense_wake_en(g_swake),
        .o_gpio_wake_en(g_gwake),
        .o_fail_drive(g_fail),
        .o_gpio_drive(g_gdrv)
    );

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            O_MEAS_ENABLE <= 1'b0;
            O_PATH_SWITCH <= 1'b0; // [RULE1]
            O_PULL_CFG <= 4'h0;
            O_SENSE_LEVEL <= 1'b0;
            O_GPIO_LEVEL <= 1'b0;
            O_STATUS_UPDATE_EN <= 1'b1;
            O_SENSE_WAKE_ACTIVE <= 1'b0;
            O_GPIO_WAKE_ACTIVE <= 1'b0;
            O_FAIL_DRIVE <= 1'b0;
            O_GPIO_DRIVE <= 1'b0;
            O_GPIO_CFG <= hv_meas_pkg::GPIO_CFG_OFF;
        end else begin
            O_MEAS_ENABLE <= meas;
            O_PATH_SWITCH <= meas && (I_MODE == hv_meas_pkg::MODE_NORMAL); // [RULE2] [RULE3] [RULE12]
            O_PULL_CFG <= g_pull; // [RULE4]
            O_SENSE_LEVEL <= g_sense;
            O_GPIO_LEVEL <= g_gpio;
            O_STATUS_UPDATE_EN <= !meas; // [RULE6]
            O_SENSE_WAKE_ACTIVE <= g_swake || (fs_entry && !meas); // [RULE13]
            O_GPIO_WAKE_ACTIVE <= g_gwake;
            O_FAIL_DRIVE <= g_fail; // [RULE8]
            O_GPIO_DRIVE <= g_gdrv;
            O_GPIO_CFG <= meas ? hv_meas_pkg::GPIO_CFG_OFF : gpio_cfg; // [RULE5]
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_switch_mode: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE2]
        ##1 O_PATH_SWITCH == ($past(meas) && $past(I_MODE) == hv_meas_pkg::MODE_NORMAL))
        else $error("switch state wrong");
    a_keep_enable: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE3]
        (meas && !I_MEAS_WR) |=> meas) else $error("enable lost");
    a_pull_off: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE4]
        meas |=> O_PULL_CFG == 4'h0) else $error("pull not off");
    a_level_cut: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE4]
        meas |=> !O_SENSE_LEVEL && !O_GPIO_LEVEL) else $error("pin level not cut");
    a_cfg_held: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE5]
        meas |=> O_GPIO_CFG == hv_meas_pkg::GPIO_CFG_OFF) else $error("pin config applied");
    a_status_frozen: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE6]
        meas |=> !O_STATUS_UPDATE_EN) else $error("status not frozen");
    a_sleep_redirect: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE7]
        (I_SLEEP_CMD && meas) |=> O_GOTO_RESTART && O_CMD_FAULT && !O_GOTO_SLEEP)
        else $error("sleep not redirected");
    a_fail_blocked: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE8]
        meas |=> !O_FAIL_DRIVE && !O_GPIO_DRIVE) else $error("fail drive active");
    a_cfg_fault: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE9]
        (I_GPIO_CFG_WR && meas) |=> O_CMD_FAULT && O_GPIO_CFG == hv_meas_pkg::GPIO_CFG_OFF)
        else $error("cfg change unflagged");
    a_set_refused: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE10]
        set_refused |=> O_CMD_FAULT && !meas) else $error("refusal wrong");
    a_wake_ignored: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE11]
        meas |=> !O_GPIO_WAKE_ACTIVE) else $error("wake acted on");
    a_sense_wake_off: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE11]
        meas |=> !O_SENSE_WAKE_ACTIVE) else $error("sense wake acted on");
    a_failsafe_open: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE12]
        (I_MODE == hv_meas_pkg::MODE_FAILSAFE) |=> !O_PATH_SWITCH) else $error("switch closed in fail-safe");
    a_fs_wake: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE13]
        (fs_entry && !meas) |=> O_SENSE_WAKE_ACTIVE) else $error("fail-safe wake missing");
    a_fault_sticky: assert property (@(posedge I_REF_CLK) disable iff (I_SRST) // [RULE14]
        (O_CMD_FAULT && !I_FAULT_CLR) |=> O_CMD_FAULT) else $error("fault dropped");
    c_fs_wake: cover property (@(posedge I_REF_CLK) disable iff (I_SRST) fs_entry && !meas);
    c_path_closed: cover property (@(posedge I_REF_CLK) disable iff (I_SRST) O_PATH_SWITCH);
    c_refused: cover property (@(posedge I_REF_CLK) disable iff (I_SRST) set_refused);
    c_restart: cover property (@(posedge I_REF_CLK) disable iff (I_SRST) O_GOTO_RESTART);
    c_reclose: cover property (@(posedge I_REF_CLK) disable iff (I_SRST)
        O_PATH_SWITCH ##1 !O_PATH_SWITCH ##[1:20] O_PATH_SWITCH);
endmodule : hv_measurement_path_control

// ===== bench/host_ctrl_model.sv
// Purpose: Host model driving the control strobes
// Assumes: One-cycle strobes, launched just after a rising edge
// Notes: Kind 0 enable, 1 pin config, 2 fault clear, 3 sleep
`timescale 1ns/100ps
module host_ctrl_model (
    input wire logic i_clk,
    output logic o_meas_wr,
    output logic o_meas_wdata,
    output logic o_gpio_cfg_wr,
    output logic [2:0] o_gpio_cfg_wdata,
    output logic o_fault_clr,
    output logic o_sleep_cmd
);
    initial begin
        {o_meas_wr, o_meas_wdata, o_gpio_cfg_wr, o_gpio_cfg_wdata, o_fault_clr, o_sleep_cmd} = 8'h00;
    end
    task automatic strobe(input int kind, input logic [2:0] data);
        @(posedge i_clk);
        #1;
        o_meas_wdata = data[0];
        o_gpio_cfg_wdata = data;
        o_meas_wr = (kind == 0);
        o_gpio_cfg_wr = (kind == 1);
        o_fault_clr = (kind == 2);
        o_sleep_cmd = (kind == 3);
        @(posedge i_clk);
        #1;
        {o_meas_wr, o_gpio_cfg_wr, o_fault_clr, o_sleep_cmd} = 4'h0;
        o_meas_wdata = ~data[0];
        o_gpio_cfg_wdata = ~data;
    endtask : strobe
    task automatic enable_measure;
        strobe(1, hv_meas_pkg::GPIO_CFG_OFF);
        strobe(0, 3'h1);
    endtask : enable_measure
endmodule : host_ctrl_model

// ===== bench/tb.sv
// Purpose: Self-checking bench for the measurement path control
// Assumes: Pins held high so gating is visible
// Notes: Results checked four cycles after a stimulus; the refused-enable fault is checked after eight
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] mode = 3'h0;
    logic [3:0] pull = 4'h5;
    logic swk = 1'b0;
    logic ft = 1'b1, frq = 1'b1, gout = 1'b1, pin_s = 1'b1, pin_g = 1'b1;
    wire logic mwr, mwd, gwr, fclr, scmd;
    wire logic [2:0] gwd, cfg_o;
    wire logic meas, sw, flt, rst_p, slp_p, lvl_s, lvl_g, upd, wk_s, wk_g, fdrv, gdrv;
    wire logic [3:0] pull_o;
    int error_cnt = 0, checks = 0, n_rst = 0, n_slp = 0, r0, m;
    host_ctrl_model i_host_ctrl_model (.i_clk(clk), .o_meas_wr(mwr), .o_meas_wdata(mwd), .o_gpio_cfg_wr(gwr),
        .o_gpio_cfg_wdata(gwd), .o_fault_clr(fclr), .o_sleep_cmd(scmd));
    hv_measurement_path_control i_hv_measurement_path_control (.I_REF_CLK(clk), .I_SRST(srst), .I_MODE(mode),
        .I_MEAS_WR(mwr), .I_MEAS_WDATA(mwd), .I_GPIO_CFG_WR(gwr), .I_GPIO_CFG_WDATA(gwd), .I_FAULT_CLR(fclr),
        .I_SLEEP_CMD(scmd), .I_PULL_CFG(pull), .I_SENSE_WAKE_EN(swk), .I_FAIL_OUTPUT_TEST(ft), .I_FAIL_REQ(frq),
        .I_GPIO_OUT(gout), .I_SENSE_PIN(pin_s), .I_GPIO_PIN(pin_g), .O_MEAS_ENABLE(meas), .O_PATH_SWITCH(sw),
        .O_CMD_FAULT(flt), .O_GOTO_RESTART(rst_p), .O_GOTO_SLEEP(slp_p), .O_PULL_CFG(pull_o), .O_SENSE_LEVEL(lvl_s),
        .O_GPIO_LEVEL(lvl_g), .O_STATUS_UPDATE_EN(upd), .O_SENSE_WAKE_ACTIVE(wk_s), .O_GPIO_WAKE_ACTIVE(wk_g),
        .O_FAIL_DRIVE(fdrv), .O_GPIO_DRIVE(gdrv), .O_GPIO_CFG(cfg_o));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst_p === 1'b1) n_rst++;
        if (slp_p === 1'b1) n_slp++;
    end
    task automatic chk(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask : chk
    task automatic chkv(input string name, input logic [3:0] exp, input logic [3:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chkv
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    task automatic go_mode(input logic [2:0] md);
        @(posedge clk);
        #1;
        mode = md;
        settle();
    endtask : go_mode
    task automatic t_reset;
        settle();
        chk("meas", 1'b0, meas);
        chk("switch", 1'b0, sw);
        chk("upd", 1'b1, upd);
        chk("sense_lvl", 1'b1, lvl_s);
        chk("gpio_lvl", 1'b1, lvl_g);
        chk("fail_drv", 1'b1, fdrv);
        chk("gpio_drv", 1'b1, gdrv);
        chk("wake", 1'b0, wk_s | wk_g);
        chkv("cfg", 4'h0, {1'b0, cfg_o});
        chkv("pull", pull, pull_o);
        $display("reset test done");
    endtask : t_reset
    task automatic t_refuse;
        i_host_ctrl_model.strobe(1, 3'h2);
        settle();
        chkv("cfg", 4'h2, {1'b0, cfg_o});
        i_host_ctrl_model.strobe(0, 3'h1);
        settle();
        chk("meas", 1'b0, meas);
        chk("switch", 1'b0, sw);
        settle();
        chk("fault", 1'b1, flt);
        i_host_ctrl_model.strobe(2, 3'h0);
        settle();
        chk("fault", 1'b0, flt);
        $display("refuse test done");
    endtask : t_refuse
    task automatic t_enable;
        swk = 1'b1;
        i_host_ctrl_model.enable_measure();
        settle();
        chk("meas", 1'b1, meas);
        chk("switch", 1'b1, sw);
        chk("lvl", 1'b0, lvl_s | lvl_g);
        chk("upd", 1'b0, upd);
        chk("wake", 1'b0, wk_s | wk_g);
        chk("drive", 1'b0, fdrv | gdrv);
        pull = 4'ha;
        settle();
        chkv("pull", 4'h0, pull_o);
        i_host_ctrl_model.strobe(1, 3'h1);
        settle();
        chk("fault", 1'b1, flt);
        chkv("cfg", 4'h0, {1'b0, cfg_o});
        i_host_ctrl_model.strobe(2, 3'h0);
        $display("enable test done");
    endtask : t_enable
    task automatic t_modes;
        for (m = 1; m <= 4; m++) begin
            go_mode(3'(m));
            chk("switch", 1'b0, sw);
            chk("meas", 1'b1, meas);
            go_mode(hv_meas_pkg::MODE_NORMAL);
            chk("switch", 1'b1, sw);
        end
        $display("mode test done");
    endtask : t_modes
    task automatic t_sleep;
        r0 = n_rst;
        i_host_ctrl_model.strobe(3, 3'h0);
        settle();
        chk("fault", 1'b1, flt);
        chk("restart", 1'b1, n_rst == r0 + 1);
        chk("nosleep", 1'b1, n_slp == 0);
        i_host_ctrl_model.strobe(2, 3'h0);
        i_host_ctrl_model.strobe(0, 3'h0);
        settle();
        chk("switch", 1'b0, sw);
        chk("upd", 1'b1, upd);
        chk("sense_lvl", 1'b1, lvl_s);
        chkv("cfg", 4'h1, {1'b0, cfg_o});
        chk("gwake", 1'b1, wk_g);
        r0 = n_slp;
        i_host_ctrl_model.strobe(3, 3'h0);
        settle();
        chk("sleep", 1'b1, n_slp == r0 + 1);
        swk = 1'b0;
        go_mode(hv_meas_pkg::MODE_FAILSAFE);
        chk("fs_wake", 1'b1, wk_s);
        $display("sleep test done");
    endtask : t_sleep
    task automatic t_rerun;
        go_mode(hv_meas_pkg::MODE_NORMAL);
        i_host_ctrl_model.enable_measure();
        i_host_ctrl_model.strobe(1, 3'h3);
        settle();
        chk("fault", 1'b1, flt);
        chk("switch", 1'b1, sw);
        @(posedge clk);
        #1;
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        settle();
        chk("meas", 1'b0, meas);
        chk("switch", 1'b0, sw);
        chk("fault", 1'b0, flt);
        chk("upd", 1'b1, upd);
        chkv("cfg", 4'h0, {1'b0, cfg_o});
        $display("rerun test done");
    endtask : t_rerun
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial begin
        #200000;
        error_cnt++;
        $display("BAD watchdog expired");
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_refuse();
        t_enable();
        t_modes();
        t_sleep();
        t_rerun();
        complete_run();
    end
endmodule : tb
